// file: include/ivd_pkg.sv
// Constants, carrier types and vector map of the interrupt vector dispatcher.
package ivd_pkg;

	localparam int NUM_SRC = 27;
	localparam int NUM_VEC = 144;
	localparam int NUM_CALL = 8;
	localparam int LVL_W = 3;
	localparam int VEC_W = 8;
	localparam int OFS_W = 10;
	localparam int SRC_IDX_W = $clog2(NUM_SRC);

	localparam logic [OFS_W-1:0] VT_TOP_OFS = 10'h3fc;
	localparam logic [VEC_W-1:0] VEC_CALL_BASE = 8'h00;
	localparam logic [VEC_W-1:0] VEC_RESET = 8'h08;
	localparam logic [VEC_W-1:0] VEC_NUM_TRAP = 8'h09;
	localparam logic [VEC_W-1:0] VEC_UNDEF = 8'h0a;
	localparam logic [VEC_W-1:0] VEC_NMI = 8'h0b;
	localparam logic [VEC_W-1:0] VEC_FIRST_PRIO = 8'h0c;
	localparam logic [LVL_W-1:0] LVL_TOP = 3'h0;
	localparam logic [LVL_W-1:0] LVL_RST = 3'h7;

	// Vector of each maskable source, in source-bit order.
	localparam logic [VEC_W-1:0] SRC_VEC [NUM_SRC] = '{
		8'h0c, 8'h0d, 8'h0e, 8'h0f, 8'h10,
		8'h11, 8'h12, 8'h13, 8'h14, 8'h15, 8'h16, 8'h17,
		8'h18, 8'h19, 8'h1a, 8'h1b, 8'h1c, 8'h1d, 8'h1e,
		8'h20, 8'h21, 8'h26, 8'h27, 8'h85, 8'h89, 8'h8a, 8'h8b
	};

	// Sources whose pending request a DMA transfer may drop.
	localparam logic [NUM_SRC-1:0] SRC_DMA_OK = 27'h3efffe0;

	// Maskable request lines; bit 0 is the delayed software request.
	typedef struct packed {
		logic        conv_range_cmp_irq;
		logic        quad_counter_irq_b;
		logic        quad_counter_irq_a;
		logic        flash_bank_irq;
		logic        pulse_gen_irq_b;
		logic        pulse_gen_irq_a;
		logic        can_unit_first_irq;
		logic        ext_pin_irq_last;
		logic [13:0] ext_pin_irq;
		logic        supply_drop_irq;
		logic        sub_osc_tick_irq;
		logic        main_osc_tick_irq;
		logic        fast_rc_tick_irq;
		logic        delayed_soft_irq;
	} ivd_src_t;

	// Trap events raised by the core, one-cycle pulses.
	typedef struct packed {
		logic       soft_call;
		logic [2:0] soft_call_idx;
		logic       numbered_soft_trap;
		logic       undefined_opcode_trap;
		logic       nmi;
	} ivd_trap_t;

	typedef struct packed {
		logic             done;
		logic [VEC_W-1:0] vec;
	} ivd_dma_t;

	typedef struct packed {
		logic             en;
		logic [VEC_W-1:0] idx;
		logic [LVL_W-1:0] lvl;
	} ivd_prio_wr_t;

	typedef struct packed {
		logic             valid;
		logic             maskable;
		logic [VEC_W-1:0] vec;
		logic [OFS_W-1:0] offset;
		logic [LVL_W-1:0] level;
	} ivd_fetch_t;

	typedef struct packed {
		logic [NUM_SRC-1:0]  pend;
		logic [NUM_CALL-1:0] call_pend;
		logic                boot_pend;
		logic                num_pend;
		logic                undef_pend;
		logic                nmi_pend;
		logic                dma_cleared;
		logic                dma_refused;
		ivd_fetch_t          fetch;
	} ivd_state_t;

	function automatic logic [OFS_W-1:0] ivd_vec_ofs(
		input logic [VEC_W-1:0] vec
	);
		return VT_TOP_OFS - {vec, 2'b00};
	endfunction

endpackage

// file: logic/ivd_prio_mem.sv
// Priority level table, one entry per vector, with a registered read port.
`timescale 1ns/1ns
module ivd_prio_mem
	import ivd_pkg::*;
#(
	parameter int DEPTH = NUM_VEC,
	parameter int W = LVL_W,
	parameter int FIRST_WR = int'(VEC_FIRST_PRIO)
) (
	// Clock and reset.
	input  logic                 i_core_clk,
	input  logic                 i_rst,
	// Write port.
	input  logic                 i_wr_en,
	input  logic [VEC_W-1:0]     i_wr_idx,
	input  logic [W-1:0]         i_wr_lvl,
	// Read port.
	input  logic [VEC_W-1:0]     i_rd_idx,
	output logic [W-1:0]         o_rd_lvl,
	// All entries, for the arbiter.
	output logic [DEPTH*W-1:0]   o_all
);

	typedef struct packed {
		logic [DEPTH-1:0][W-1:0] ent;
		logic [W-1:0]            rd;
	} ivd_mem_st_t;

	ivd_mem_st_t st_ff;
	ivd_mem_st_t nxt_st;

	always_comb begin
		nxt_st = st_ff;
		// Entries below the first prioritised vector stay disabled.
		if (i_wr_en && i_wr_idx >= FIRST_WR && i_wr_idx < DEPTH) begin
			nxt_st.ent[i_wr_idx] = i_wr_lvl;
		end
		if (i_rd_idx < DEPTH) begin
			nxt_st.rd = st_ff.ent[i_rd_idx];
		end else begin
			nxt_st.rd = '0;
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			st_ff.ent <= {DEPTH{W'(LVL_RST)}};
			st_ff.rd  <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign o_rd_lvl = st_ff.rd;
	assign o_all    = st_ff.ent;

endmodule

// file: logic/ivd_pick.sv
// Picks the most urgent request: lowest level, lower index on a tie.
`timescale 1ns/1ns
module ivd_pick
	import ivd_pkg::*;
#(
	parameter int N = NUM_SRC,
	parameter int W = LVL_W,
	parameter int IW = $clog2(N)
) (
	// Requests and their levels.
	input  logic [N-1:0]   i_req,
	input  logic [N*W-1:0] i_lvl,
	input  logic [W-1:0]   i_ceil,
	// Winner.
	output logic           o_found,
	output logic [IW-1:0]  o_idx,
	output logic [W-1:0]   o_lvl
);

	always_comb begin
		o_found = 1'b0;
		o_idx   = '0;
		o_lvl   = i_ceil;
		// Strict compare keeps the earlier index, which has the lower vector.
		for (int i = 0; i < N; i++) begin
			if (i_req[i] && i_lvl[i*W +: W] < o_lvl) begin
				o_found = 1'b1;
				o_idx   = IW'(i);
				o_lvl   = i_lvl[i*W +: W];
			end
		end
	end

endmodule

// file: logic/ivd_dispatch.sv
// Interrupt vector dispatcher: pending requests, DMA clearing, vector fetch.
`timescale 1ns/1ns

module ivd_dispatch
	import ivd_pkg::*;
(
	// Clock and reset.
	input  logic                 i_core_clk,
	input  logic                 i_rst,
	// Peripheral request pulses.
	input  ivd_src_t             i_src,
	// Core trap events and level ceiling.
	input  ivd_trap_t            i_trap,
	input  logic [LVL_W-1:0]     i_core_ilm,
	// Level table access from the core.
	input  ivd_prio_wr_t         i_prio_wr,
	input  logic [VEC_W-1:0]     i_prio_rd_idx,
	output logic [LVL_W-1:0]     o_prio_rd_level,
	// DMA completion.
	input  ivd_dma_t             i_dma,
	output logic                 o_dma_cleared,
	output logic                 o_dma_refused,
	// Vector fetch towards the core.
	output ivd_fetch_t           o_fetch,
	input  logic                 i_fetch_ack,
	// Pending view.
	output ivd_src_t             o_pending
);

	localparam ivd_state_t ST_RST = '{boot_pend: 1'b1, default: '0};

	ivd_state_t st_ff;
	ivd_state_t nxt_st;

	logic [NUM_VEC*LVL_W-1:0] prio_all;
	logic [NUM_SRC*LVL_W-1:0] src_lvl;
	logic [NUM_SRC-1:0]       ack_clr;
	logic [NUM_SRC-1:0]       dma_clr;
	logic [NUM_SRC-1:0]       src_av;
	logic [NUM_CALL-1:0]      call_av;
	logic [NUM_CALL-1:0]      call_set;
	logic                     ack_irq;
	logic                     ack_trap;
	logic                     boot_av;
	logic                     num_av;
	logic                     undef_av;
	logic                     nmi_av;
	logic                     hold;
	logic                     win_found;
	logic [SRC_IDX_W-1:0]     win_idx;
	logic [LVL_W-1:0]         win_lvl;

	ivd_prio_mem #(
		.DEPTH    (NUM_VEC),
		.W        (LVL_W),
		.FIRST_WR (int'(VEC_FIRST_PRIO))
	) u_prio_mem (
		.i_core_clk (i_core_clk),
		.i_rst      (i_rst),
		.i_wr_en    (i_prio_wr.en),
		.i_wr_idx   (i_prio_wr.idx),
		.i_wr_lvl   (i_prio_wr.lvl),
		.i_rd_idx   (i_prio_rd_idx),
		.o_rd_lvl   (o_prio_rd_level),
		.o_all      (prio_all)
	);

	// An acknowledge always refers to the vector currently shown.
	assign ack_irq  = i_fetch_ack && st_ff.fetch.valid && st_ff.fetch.maskable;
	assign ack_trap = i_fetch_ack && st_ff.fetch.valid && !st_ff.fetch.maskable;

	for (genvar g = 0; g < NUM_SRC; g++) begin : g_src
		// Level comes from the entry whose index equals the vector.
		assign src_lvl[g*LVL_W +: LVL_W] =
			prio_all[int'(SRC_VEC[g])*LVL_W +: LVL_W];
		assign ack_clr[g] = ack_irq &&
			st_ff.fetch.vec == SRC_VEC[g];
		// Only sources marked clearable react to a DMA completion.
		assign dma_clr[g] = i_dma.done && i_dma.vec == SRC_VEC[g] &&
			SRC_DMA_OK[g];
		assign src_av[g] = st_ff.pend[g] && !ack_clr[g] && !dma_clr[g];
	end

	for (genvar k = 0; k < NUM_CALL; k++) begin : g_call
		assign call_av[k] = st_ff.call_pend[k] && !(ack_trap &&
			st_ff.fetch.vec == VEC_CALL_BASE + VEC_W'(k));
		assign call_set[k] = i_trap.soft_call &&
			i_trap.soft_call_idx == 3'(k);
	end

	// Non-maskable flags ignore DMA entirely; only the core's ack drops them.
	assign boot_av = st_ff.boot_pend &&
		!(ack_trap && st_ff.fetch.vec == VEC_RESET);
	assign num_av = st_ff.num_pend &&
		!(ack_trap && st_ff.fetch.vec == VEC_NUM_TRAP);
	assign undef_av = st_ff.undef_pend &&
		!(ack_trap && st_ff.fetch.vec == VEC_UNDEF);
	assign nmi_av = st_ff.nmi_pend &&
		!(ack_trap && st_ff.fetch.vec == VEC_NMI);

	ivd_pick #(
		.N  (NUM_SRC),
		.W  (LVL_W),
		.IW (SRC_IDX_W)
	) u_pick (
		.i_req   (src_av),
		.i_lvl   (src_lvl),
		.i_ceil  (i_core_ilm),
		.o_found (win_found),
		.o_idx   (win_idx),
		.o_lvl   (win_lvl)
	);

	// A trap stays on show until taken; a maskable vector may be replaced.
	assign hold = st_ff.fetch.valid && !st_ff.fetch.maskable && !i_fetch_ack;

	function automatic ivd_fetch_t mk_fetch(
		input logic [VEC_W-1:0] vec,
		input logic             maskable,
		input logic [LVL_W-1:0] level
	);
		ivd_fetch_t f;
		f.valid    = 1'b1;
		f.maskable = maskable;
		f.vec      = vec;
		f.offset   = ivd_vec_ofs(vec);
		f.level    = level;
		return f;
	endfunction

	always_comb begin
		logic [2:0] call_sel;
		logic       call_any;
		call_sel = '0;
		call_any = |call_av;
		for (int k = NUM_CALL - 1; k >= 0; k--) begin
			if (call_av[k]) begin
				call_sel = 3'(k);
			end
		end

		nxt_st = st_ff;

		// A new pulse in the clearing cycle survives: set wins over clear.
		nxt_st.pend       = src_av | i_src;
		nxt_st.call_pend  = call_av | call_set;
		nxt_st.boot_pend  = boot_av;
		nxt_st.num_pend   = num_av | i_trap.numbered_soft_trap;
		nxt_st.undef_pend = undef_av | i_trap.undefined_opcode_trap;
		nxt_st.nmi_pend   = nmi_av | i_trap.nmi;

		nxt_st.dma_cleared = |dma_clr;
		nxt_st.dma_refused = i_dma.done && !(|dma_clr);

		if (!hold) begin
			nxt_st.fetch = '0;
			if (boot_av) begin
				nxt_st.fetch = mk_fetch(VEC_RESET, 1'b0, LVL_TOP);
			end else if (undef_av) begin
				nxt_st.fetch = mk_fetch(VEC_UNDEF, 1'b0, LVL_TOP);
			end else if (num_av) begin
				nxt_st.fetch = mk_fetch(VEC_NUM_TRAP, 1'b0, LVL_TOP);
			end else if (call_any) begin
				nxt_st.fetch = mk_fetch(VEC_CALL_BASE + VEC_W'(call_sel),
					1'b0, LVL_TOP);
			end else if (nmi_av) begin
				nxt_st.fetch = mk_fetch(VEC_NMI, 1'b0, LVL_TOP);
			end else if (win_found) begin
				nxt_st.fetch = mk_fetch(SRC_VEC[win_idx], 1'b1, win_lvl);
			end
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			st_ff <= ST_RST;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign o_fetch       = st_ff.fetch;
	assign o_pending     = ivd_src_t'(st_ff.pend);
	assign o_dma_cleared = st_ff.dma_cleared;
	assign o_dma_refused = st_ff.dma_refused;

endmodule

// file: tb/ivd_core_model.sv
// Core-side model that takes each shown vector after a random stall.
`timescale 1ns/1ns
module ivd_core_model
	import ivd_pkg::*;
(
	// Clock and reset.
	input  logic       i_core_clk,
	input  logic       i_rst,
	// Fetch side.
	input  ivd_fetch_t i_fetch,
	input  logic       i_stall,
	output logic       o_ack = 1'b0
);
	// The ack is a one-cycle pulse.
	// After an ack the model waits one cycle, so it never takes a stale vector.
	always @(posedge i_core_clk) begin
		o_ack <= !i_rst && i_fetch.valid && !o_ack && !i_stall;
	end
endmodule

// file: tb/ivd_dispatch_monitor.sv
// Concurrent checks on the dispatcher's ports.
`timescale 1ns/1ns
module ivd_dispatch_monitor
	import ivd_pkg::*;
(
	// Clock and reset.
	input logic             i_core_clk,
	input logic             i_rst,
	// Watched ports.
	input ivd_src_t         i_src,
	input logic [LVL_W-1:0] i_core_ilm,
	input ivd_dma_t         i_dma,
	input logic             o_dma_cleared,
	input logic             o_dma_refused,
	input ivd_fetch_t       o_fetch,
	input logic             i_fetch_ack,
	input ivd_src_t         o_pending
);
	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (i_rst);

	a_offset_map: assert property (o_fetch.valid |->
		o_fetch.offset == 10'h3fc - {o_fetch.vec, 2'b00})
		else $error("vector offset wrong");
	a_reset_vec: assert property ($fell(i_rst) |=> o_fetch.valid &&
		o_fetch.vec == 8'h08 && o_fetch.offset == 10'h3dc)
		else $error("reset vector not shown");
	a_trap_hold: assert property (o_fetch.valid && !o_fetch.maskable &&
		!i_fetch_ack |=> $stable(o_fetch)) else $error("trap vector moved");
	a_dma_answer: assert property (i_dma.done |=>
		o_dma_cleared != o_dma_refused) else $error("no single answer");
	a_dma_cause: assert property (o_dma_cleared || o_dma_refused |->
		$past(i_dma.done)) else $error("answer without transfer");
	a_dma_drop: assert property (i_dma.done && i_dma.vec == 8'h11 &&
		!i_src.ext_pin_irq[0] |=> o_dma_cleared && !o_pending.ext_pin_irq[0])
		else $error("pin request not dropped");
	a_dma_keep: assert property (i_dma.done && (i_dma.vec < 8'h11 ||
		i_dma.vec == 8'h21 || i_dma.vec == 8'h8b) |=> o_dma_refused)
		else $error("protected request cleared");
	a_pend_set: assert property (i_src.pulse_gen_irq_a |=>
		o_pending.pulse_gen_irq_a) else $error("request not held");
	a_ceiling: assert property (o_fetch.valid && o_fetch.maskable |->
		o_fetch.level < $past(i_core_ilm)) else $error("level above ceiling");
endmodule

bind ivd_dispatch ivd_dispatch_monitor ivd_dispatch_monitor_inst (
	.i_core_clk(i_core_clk), .i_rst(i_rst), .i_src(i_src),
	.i_core_ilm(i_core_ilm), .i_dma(i_dma),
	.o_dma_cleared(o_dma_cleared), .o_dma_refused(o_dma_refused),
	.o_fetch(o_fetch), .i_fetch_ack(i_fetch_ack), .o_pending(o_pending)
);

// file: tb/ivd_dispatch_test.sv
// Self-checking bench of the interrupt vector dispatcher.
`timescale 1ns/1ns
`define CHK(a, b, m) chk((a) === (b), m)
module ivd_dispatch_test;
	import ivd_pkg::*;
	logic             clk = 0;
	logic             rst = 1;
	logic             stall = 0;
	logic             ack;
	logic             clr;
	logic             rfs;
	ivd_src_t         src = '0;
	ivd_src_t         pend;
	ivd_trap_t        trap = '0;
	ivd_prio_wr_t     pw = '0;
	ivd_dma_t         dma = '0;
	ivd_fetch_t       f;
	logic [LVL_W-1:0] ilm = 3'h7;
	logic [LVL_W-1:0] rd_lvl;
	logic [VEC_W-1:0] rd_idx = 8'h00;
	logic [VEC_W-1:0] v;
	logic [LVL_W-1:0] exp_lvl;
	ivd_fetch_t       got_q [$];
	int               lv [NUM_SRC];
	int               failures = 0;
	int               total_checks = 0;
	int               cyc = 0;
	int               a;
	int               b;
	int               w;

	always #25 clk = ~clk;

	ivd_dispatch ivd_dispatch_inst (
		.i_core_clk(clk), .i_rst(rst), .i_src(src), .i_trap(trap),
		.i_core_ilm(ilm), .i_prio_wr(pw), .i_prio_rd_idx(rd_idx),
		.o_prio_rd_level(rd_lvl), .i_dma(dma), .o_dma_cleared(clr),
		.o_dma_refused(rfs), .o_fetch(f), .i_fetch_ack(ack),
		.o_pending(pend)
	);
	ivd_core_model ivd_core_model_inst (
		.i_core_clk(clk), .i_rst(rst), .i_fetch(f), .i_stall(stall),
		.o_ack(ack)
	);

	task automatic chk(input bit ok, input string m);
		total_checks++;
		if (!ok) begin
			failures++;
			$display("wrong value at %0t: %s", $time, m);
		end
	endtask

	task automatic final_report();
		$display("checks %0d, mismatches %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	function automatic logic [VEC_W-1:0] vof(input int k);
		int hi [8] = '{32, 33, 38, 39, 133, 137, 138, 139};
		return (k < 19) ? VEC_W'(12 + k) : VEC_W'(hi[k - 19]);
	endfunction

	function automatic bit dok(input int k);
		return (k >= 5 && k <= 19) || (k >= 21 && k <= 25);
	endfunction

	// Each vector that the core takes is queued in order.
	always @(posedge clk) begin
		cyc <= cyc + 1;
		stall <= ($urandom_range(0, 3) == 0);
		if (ack && f.valid)
			got_q.push_back(f);
		if (cyc == 20000) begin
			failures++;
			final_report();
		end
	end

	task automatic take(input logic [VEC_W-1:0] e, input string m);
		ivd_fetch_t g;
		int n;
		int lvl;
		n = 0;
		lvl = 0;
		// Traps and the reset entry are shown at the top level.
		for (int k = 0; k < NUM_SRC; k++)
			if (vof(k) == e)
				lvl = lv[k];
		while (got_q.size() == 0 && n < 80) begin
			@(posedge clk);
			n++;
		end
		g = (got_q.size() > 0) ? got_q.pop_front() : '0;
		`CHK({g.valid, g.vec}, {1'b1, e}, m);
		`CHK(g.offset, 10'h3fc - 10'(4 * e), m);
		`CHK(g.maskable, e >= VEC_FIRST_PRIO, m);
		`CHK(g.level, LVL_W'(lvl), m);
	endtask

	task automatic pulse(input ivd_src_t s);
		@(posedge clk);
		src <= s;
		@(posedge clk);
		src <= '0;
	endtask

	initial begin
		void'($urandom(23));
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		take(8'h08, "reset vector");
		$display("test reset done");
		for (int i = 0; i < 11; i++) begin
			@(posedge clk);
			trap <= (i < 8) ? {1'b1, 3'(i), 3'b000} : 7'(1 << (10 - i));
			@(posedge clk);
			trap <= '0;
			take((i < 8) ? 8'(i) : 8'(i + 1), "trap vector");
		end
		@(posedge clk);
		trap <= 7'h7f;
		@(posedge clk);
		trap <= '0;
		take(8'h0a, "trap order");
		take(8'h09, "trap order");
		take(8'h07, "trap order");
		take(8'h0b, "trap order");
		$display("test traps done");
		for (int k = 0; k < NUM_SRC; k++) begin
			lv[k] = $urandom_range(0, 6);
			@(posedge clk);
			pw <= '{1'b1, vof(k), 3'(lv[k])};
		end
		@(posedge clk);
		pw <= '{1'b1, 8'h05, 3'h1};
		@(posedge clk);
		pw <= '{1'b1, 8'h90, 3'h3};
		@(posedge clk);
		pw <= '0;
		// Entry 5 lies below the prioritised range and keeps its reset level.
		for (int k = 0; k <= NUM_SRC + 1; k++) begin
			@(posedge clk);
			rd_idx <= (k < NUM_SRC) ? vof(k) : (k == NUM_SRC) ? 8'h05 : 8'h90;
			@(posedge clk);
			@(posedge clk);
			#1;
			exp_lvl = (k < NUM_SRC) ? 3'(lv[k]) :
				(k == NUM_SRC) ? LVL_RST : 3'h0;
			`CHK(rd_lvl, exp_lvl, "level");
		end
		$display("test levels done");
		for (int k = 0; k < NUM_SRC; k++) begin
			pulse(ivd_src_t'(27'h1 << k));
			take(vof(k), "source");
		end
		$display("test sources done");
		for (int j = 0; j < 12; j++) begin
			a = $urandom_range(0, 26);
			b = (a + 1 + $urandom_range(0, 25)) % NUM_SRC;
			pulse(ivd_src_t'((27'h1 << a) | (27'h1 << b)));
			w = (lv[a] < lv[b] || (lv[a] == lv[b] && a < b)) ? a : b;
			take(vof(w), "winner");
			take(vof(a + b - w), "loser");
		end
		$display("test priority done");
		// A zero ceiling keeps requests pending so the transfer meets them.
		ilm <= 3'h0;
		for (int k = 0; k < NUM_SRC + 2; k++) begin
			if (k < NUM_SRC)
				pulse(ivd_src_t'(27'h1 << k));
			v = (k < NUM_SRC) ? vof(k) : (k == NUM_SRC) ? 8'h1f : 8'h08;
			@(posedge clk);
			dma <= '{1'b1, v};
			@(posedge clk);
			dma <= '0;
			#1;
			`CHK({clr, rfs}, {dok(k), !dok(k)}, "dma answer");
			if (k < NUM_SRC)
				`CHK(pend[k], !dok(k), "dma pending");
		end
		`CHK(got_q.size(), 0, "masked shown");
		ilm <= 3'h7;
		repeat (300) @(posedge clk);
		got_q.delete();
		`CHK(pend, ivd_src_t'(0), "pending left");
		$display("test dma done");
		final_report();
	end
endmodule
